// File: logic/ieg_pkg.sv
package ieg_pkg;
   // Vector and flag constants
   localparam int          VEC_W          = 8;          // Vector width
   localparam logic [7:0]  NMI_VECTOR     = 8'h02;      // Fixed nonmaskable vector
   localparam logic [7:0]  DBG_VECTOR     = 8'h01;      // Debug exception vector
   localparam logic [7:0]  GPF_VECTOR     = 8'h0d;      // General protection vector
   localparam logic [7:0]  PIN_VEC_MAX    = 8'h20;      // Highest vector on the pin
   localparam logic [7:0]  LIC_VEC_MIN    = 8'h10;      // Lowest controller vector
   localparam logic [7:0]  LIC_VEC_MAX    = 8'h20;      // Highest controller vector
   localparam int          IF_BIT         = 9;          // Enable flag position
   localparam int          RF_BIT         = 16;         // Resume flag position
   localparam logic [31:0] FLAGS_RESET    = 32'h00000002; // Flags after reset
   localparam logic [1:0]  IO_PRIV_LEVEL_FULL      = 2'h3;       // Privilege of full access

   // Dispatch class, trap listed ahead of abort, the rest highest priority first
   typedef enum logic [2:0] {
      IEG_EV_NONE,
      IEG_EV_TRAP,
      IEG_EV_ABORT,
      IEG_EV_NMI,
      IEG_EV_MASKABLE,
      IEG_EV_DEBUG,
      IEG_EV_FAULT
   } ieg_event_t;
endpackage : ieg_pkg

// File: logic/ieg_gate.sv
module ieg_gate (
   input  wire logic                       clock_in,           // Core clock
   input  wire logic                       rst_b_in,           // Async reset, active low
   input  wire logic                       retire_valid_in,    // In-order retirement boundary
   input  wire logic [31:0]                retire_next_ip_in,  // Sequential next pointer
   input  wire logic                       retire_branch_in,   // Instruction transferred control
   input  wire logic [31:0]                retire_target_in,   // Transfer destination
   input  wire logic                       retire_rep_in,      // Repeat-prefixed iteration
   input  wire logic                       retire_rep_done_in, // Final repeat iteration
   input  wire logic [31:0]                retire_ip_in,       // Pointer of retiring instr
   input  wire logic                       trap_in,            // Trap on retiring instr
   input  wire logic                       fault_in,           // Fault on retiring instr
   input  wire logic [ieg_pkg::VEC_W-1:0]  fault_vec_in,       // Fault vector
   input  wire logic                       abort_in,           // Abort-class exception
   input  wire logic [ieg_pkg::VEC_W-1:0]  exc_vec_in,         // Trap or abort vector
   input  wire logic                       ibp_match_in,       // Instruction breakpoint hit
   input  wire logic                       nmi_pin_in,         // Dedicated nonmaskable pin
   input  wire logic                       nmi_msg_in,         // Nonmaskable bus message
   input  wire logic                       maskable_request_pin_in, // Maskable pin
   input  wire logic [ieg_pkg::VEC_W-1:0]  pin_vec_in,         // Vector on the pin
   input  wire logic                       lic_req_in,         // Local controller request
   input  wire logic [ieg_pkg::VEC_W-1:0]  lic_vec_in,         // Controller vector
   input  wire logic                       set_int_enable_instr_in,   // Set enable instr
   input  wire logic                       clear_int_enable_instr_in, // Clear enable instr
   input  wire logic                       pop_flags_instr_in,        // Flags pop
   input  wire logic                       interrupt_return_instr_in, // Interrupt return
   input  wire logic                       task_switch_in,            // Task switch load
   input  wire logic [31:0]                flags_load_in,      // Loaded flags image
   input  wire logic                       v86_in,             // Handler is a v86 task
   input  wire logic [1:0]                 current_priv_level_in, // Privilege now
   input  wire logic [1:0]                 io_priv_level_in,   // I/O privilege level
   input  wire logic                       gate_is_maskable_request_pin_in,    // Dispatch gate is interrupt
   output logic                            dispatch_out,       // Dispatch pulse
   output ieg_pkg::ieg_event_t             dispatch_class_out, // Class dispatched
   output logic [ieg_pkg::VEC_W-1:0]       dispatch_vec_out,   // Handler vector
   output logic [31:0]                     return_ip_out,      // Saved return pointer
   output logic                            error_code_ok_out,  // May push error code
   output logic                            restartable_out,    // Return state reliable
   output logic                            maskable_ack_out,   // Pin request taken
   output logic                            lic_ack_out,        // Controller request taken
   output logic                            lic_illegal_out,    // Illegal controller vector
   output logic [31:0]                     flags_register_out, // Flags image
   output logic                            nmi_blocked_out     // Nonmaskable blocking
);
   import ieg_pkg::*;

   // Overview of the decision made at each boundary:
   // Nothing here looks ahead of retirement; every event except an illegal
   // Controller vector is weighed only in the cycle that presents an in-order boundary.
   // The chosen event is registered, so the handler side sees one
   // Clean pulse with class, vector and return pointer together.
   // Flags and nonmaskable blocking are kept here as well, because
   // The gating decision needs their values of this very cycle.
   // Trade-off: all decisions are single cycle and combinational;
   // A deeper core would need to pipeline the priority chain.
   // Limitation: descriptor lookup and stack switching live elsewhere;
   // The gate type arrives already resolved on its own input.
   // Limitation: lower-priority exceptions are simply dropped and
   // Rely on the retiring instruction raising them again later.

   // Architectural state
   logic [31:0] flags_register;  // Flags image
   logic        nmi_blocked;     // Blocking until interrupt return
   logic        nmi_pending;     // Latched nonmaskable edge
   logic        nmi_pin_d;       // Pin history for edge detect

   // Vector range check, used for both maskable sources
   function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                     input logic [7:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction : in_range

   // Privileged flag instructions
   // A set or clear of the enable flag is honoured only when the
   // Current privilege does not exceed the I/O privilege level.
   // Otherwise the flag stays as it was and a protection fault is
   // Raised instead, at the lowest class of the priority chain.
   // The same fault path serves a low-privilege return from a v86
   // Nonmaskable handler, which must still release the blocking.
   wire priv_ok   = current_priv_level_in <= io_priv_level_in;
   wire flag_instr = set_int_enable_instr_in | clear_int_enable_instr_in;
   wire priv_gpf  = flag_instr & ~priv_ok;
   // Return from a v86 handler with low privilege faults
   wire interrupt_return_instr_gpf  = interrupt_return_instr_in & v86_in & (io_priv_level_in < IO_PRIV_LEVEL_FULL);
   wire interrupt_return_instr_ok   = interrupt_return_instr_in & ~interrupt_return_instr_gpf;
   wire gpf       = priv_gpf | interrupt_return_instr_gpf;

   // Nonmaskable sources:
   // The pin is level driven, so only its rising edge counts; a pin
   // Held high must not request a second handler entry on return.
   // The message is a one-cycle pulse and counts as it stands.
   // A request that arrives off a boundary, or while blocked, is kept
   // In the pending latch until it can be taken.
   // Hazard: a second edge while one is pending is merged into it;
   // The handler sees one entry for both, which is intended.
   // Nonmaskable from either source, edge on the pin
   wire nmi_new   = (nmi_pin_in & ~nmi_pin_d) | nmi_msg_in;
   wire nmi_req   = nmi_pending | nmi_new;
   // Any interrupt return unblocks, even one that faults
   wire unblock   = interrupt_return_instr_in;
   wire blocked   = nmi_blocked & ~unblock;
   wire if_now    = flags_register[IF_BIT];
   wire rf_now    = flags_register[RF_BIT];

   // Maskable requests:
   // Both sources are levels held by the outside controller until
   // Acknowledged; refusing one here simply leaves it pending.
   // The pin accepts the whole low range, the controller only its
   // Upper part; a controller vector below that is flagged illegal.
   // A low vector on either source is an interrupt, never a real
   // Exception, so no error code accompanies it.
   // Maskable requests gated by flag and vector range
   wire pin_ok    = maskable_request_pin_in & if_now
                    & in_range(pin_vec_in, 8'h00, PIN_VEC_MAX);
   wire lic_ok    = lic_req_in & if_now
                    & in_range(lic_vec_in, LIC_VEC_MIN, LIC_VEC_MAX);
   wire lic_bad   = lic_req_in & ~in_range(lic_vec_in, 8'h00, LIC_VEC_MAX)
                    ? 1'b0 : lic_req_in & (lic_vec_in < LIC_VEC_MIN);
   wire dbg_hit   = ibp_match_in & ~rf_now;

   // Priority chain:
   // Abort first, since the machine state can no longer be trusted.
   // Then a trap of the instruction just completed, then the
   // Nonmaskable request, then maskable requests, then the code
   // Breakpoint, and last the faults of the retiring instruction.
   // Each take signal excludes all that stand above it, so at most
   // One of them is ever high in a cycle.
   // Interrupts not chosen stay pending, maskable ones at their source and a nonmaskable one in its latch; exceptions
   // Not chosen are dropped and come back when the code reruns.
   // Events are only evaluated at a retirement boundary
   wire at_bound  = retire_valid_in;
   wire take_abort = at_bound & abort_in;
   wire take_trap  = at_bound & ~take_abort & trap_in;
   wire take_nmi   = at_bound & ~take_abort & ~take_trap & nmi_req & ~blocked;
   wire take_mask  = at_bound & ~take_abort & ~take_trap & ~take_nmi & ~blocked
                     & (pin_ok | lic_ok);
   wire take_dbg   = at_bound & ~take_abort & ~take_trap & ~take_nmi & ~take_mask & dbg_hit;
   wire take_fault = at_bound & ~take_abort & ~take_trap & ~take_nmi & ~take_mask
                     & ~take_dbg & (fault_in | gpf);
   wire any_take   = take_abort | take_trap | take_nmi | take_mask | take_dbg | take_fault;

   // Return pointers:
   // A completed instruction continues at its successor, which for a
   // Control transfer is the destination and not the next address.
   // An interrupted repeat iteration continues at the same pointer,
   // With the count registers already set for the next iteration.
   // Next-instruction pointer after a completed instruction
   wire [31:0] seq_next  = retire_branch_in ? retire_target_in : retire_next_ip_in;
   // Unfinished repeat resumes at same instruction, next iteration
   wire [31:0] int_next  = (retire_rep_in & ~retire_rep_done_in) ? retire_ip_in
                                                                  : seq_next;

   // Selected class, vector and pointer
   // Defaults describe a fault: restart the retiring instruction.
   // Only one branch can be true, as the take signals are exclusive.
   ieg_event_t next_class;
   logic [7:0] next_vec;
   logic [31:0] next_ret;
   always_comb begin
      next_class = IEG_EV_NONE;
      next_vec   = 8'h00;
      next_ret   = retire_ip_in;
      if (take_abort) begin
         next_class = IEG_EV_ABORT;
         next_vec   = exc_vec_in;
      end else if (take_trap) begin
         next_class = IEG_EV_TRAP;
         next_vec   = exc_vec_in;
         next_ret   = seq_next;
      end else if (take_nmi) begin
         next_class = IEG_EV_NMI;
         next_vec   = NMI_VECTOR;
         next_ret   = int_next;
      end else if (take_mask) begin
         next_class = IEG_EV_MASKABLE;
         // Pin wins over controller; the other stays pending
         next_vec   = pin_ok ? pin_vec_in : lic_vec_in;
         next_ret   = int_next;
      end else if (take_dbg) begin
         next_class = IEG_EV_DEBUG;
         next_vec   = DBG_VECTOR;
      end else if (take_fault) begin
         // Faults restart the faulting instruction
         next_class = IEG_EV_FAULT;
         next_vec   = gpf ? GPF_VECTOR : fault_vec_in;
      end
   end

   // Flags image update; later writers win within a cycle
   // A whole-image load comes first, then the flag instructions, and
   // A dispatch through an interrupt gate last, because the handler
   // Entry happens after the retiring instruction has finished.
   // A faulting flag instruction leaves the image untouched.
   logic [31:0] next_flags;
   always_comb begin
      next_flags = flags_register;
      if (at_bound & (task_switch_in | pop_flags_instr_in | interrupt_return_instr_ok))
         next_flags = flags_load_in;
      if (at_bound & priv_ok & set_int_enable_instr_in)
         next_flags[IF_BIT] = 1'b1;
      if (at_bound & priv_ok & clear_int_enable_instr_in)
         next_flags[IF_BIT] = 1'b0;
      if (any_take & gate_is_maskable_request_pin_in)
         next_flags[IF_BIT] = 1'b0;
   end

   // Flag and blocking registers
   // Reset leaves maskable requests disabled and the nonmaskable path
   // Open, so the first nonmaskable request after reset is taken.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flags_register <= FLAGS_RESET;
         nmi_blocked    <= 1'b0;
         nmi_pending    <= 1'b0;
         nmi_pin_d      <= 1'b0;
      end else begin
         flags_register <= next_flags;
         nmi_pin_d      <= nmi_pin_in;
         // Taken request clears, together with any new edge in that cycle
         nmi_pending    <= (nmi_pending & ~take_nmi) | (nmi_new & ~take_nmi);
         if (take_nmi)
            nmi_blocked <= 1'b1;
         else if (unblock & at_bound)
            nmi_blocked <= 1'b0;
      end
   end

   // Registered dispatch outputs
   // All but lic_illegal_out stand for exactly one cycle after the taking edge; the
   // Handler side must capture them in that cycle.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dispatch_out       <= 1'b0;
         dispatch_class_out <= IEG_EV_NONE;
         dispatch_vec_out   <= 8'h00;
         return_ip_out      <= 32'h00000000;
         error_code_ok_out  <= 1'b0;
         restartable_out    <= 1'b1;
         maskable_ack_out   <= 1'b0;
         lic_ack_out        <= 1'b0;
         lic_illegal_out    <= 1'b0;
      end else begin
         dispatch_out       <= any_take;
         dispatch_class_out <= next_class;
         dispatch_vec_out   <= next_vec;
         return_ip_out      <= next_ret;
         // Only processor exceptions may carry an error code
         error_code_ok_out  <= take_fault | take_abort | take_trap;
         restartable_out    <= ~take_abort;
         maskable_ack_out   <= take_mask & pin_ok;
         lic_ack_out        <= take_mask & ~pin_ok;
         lic_illegal_out    <= lic_bad;
      end
   end

   // Status views
   // These mirror the internal registers one for one, so outside
   // Logic sees the same values that gate the next boundary.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flags_register_out <= FLAGS_RESET;
         nmi_blocked_out    <= 1'b0;
      end else begin
         flags_register_out <= next_flags;
         nmi_blocked_out    <= take_nmi | (nmi_blocked & ~(unblock & at_bound));
      end
   end
endmodule : ieg_gate

// File: sim/ieg_gate_asserts.sv
module ieg_gate_asserts
   import ieg_pkg::*;
(
   input wire logic                clock_in,           // Core clock
   input wire logic                rst_b_in,           // Reset, active low
   input wire logic                retire_valid_in,    // Boundary strobe
   input wire logic                retire_branch_in,   // Control transferred
   input wire logic [31:0]         retire_next_ip_in,  // Sequential pointer
   input wire logic [31:0]         retire_target_in,   // Transfer target
   input wire logic [7:0]          pin_vec_in,         // Pin vector
   input wire logic                dispatch_out,       // Dispatch pulse
   input wire ieg_pkg::ieg_event_t dispatch_class_out, // Class taken
   input wire logic [7:0]          dispatch_vec_out,   // Handler vector
   input wire logic [31:0]         return_ip_out,      // Saved pointer
   input wire logic                error_code_ok_out,  // Error code allowed
   input wire logic                restartable_out,    // Restart state
   input wire logic                maskable_ack_out,   // Pin taken
   input wire logic [31:0]         flags_register_out, // Flags image
   input wire logic                nmi_blocked_out     // Blocking state
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   wire is_nmi = dispatch_out && dispatch_class_out == IEG_EV_NMI; // Nonmaskable taken
   a_nmi_vec_block: assert property (is_nmi |-> dispatch_vec_out == NMI_VECTOR && nmi_blocked_out)
      else $error("nonmaskable dispatch wrong");
   a_reset_state: assert property (!$past(rst_b_in) |-> flags_register_out == FLAGS_RESET && !nmi_blocked_out)
      else $error("state after reset wrong");
   a_take_in_order: assert property (dispatch_out |-> $past(retire_valid_in))
      else $error("dispatch without boundary");
   a_trap_return: assert property (dispatch_out && dispatch_class_out == IEG_EV_TRAP |-> return_ip_out == ($past(retire_branch_in) ? $past(retire_target_in) : $past(retire_next_ip_in)))
      else $error("trap return pointer wrong");
   a_abort_unsafe: assert property (dispatch_out && dispatch_class_out == IEG_EV_ABORT |-> !restartable_out)
      else $error("abort marked restartable");
   a_mask_needs_if: assert property (maskable_ack_out |-> $past(flags_register_out[IF_BIT]) && !$past(nmi_blocked_out))
      else $error("masked request taken");
   a_pin_range: assert property (maskable_ack_out |-> $past(pin_vec_in) <= PIN_VEC_MAX)
      else $error("pin vector out of range taken");
   a_no_err_code: assert property (dispatch_out && dispatch_class_out == IEG_EV_MASKABLE |-> !error_code_ok_out)
      else $error("error code on external request");
endmodule : ieg_gate_asserts
bind ieg_gate ieg_gate_asserts u_asserts (.*);

// File: sim/ieg_irq_src.sv
module ieg_irq_src (
   input  wire logic  clock_in,    // Core clock
   output logic       nmi_pin_out, // Nonmaskable pin
   output logic       nmi_msg_out, // Nonmaskable message
   output logic       int_req_out, // Maskable pin level
   output logic [7:0] int_vec_out, // Pin vector
   output logic       lic_req_out, // Controller request
   output logic [7:0] lic_vec_out  // Controller vector
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {nmi_pin_out, nmi_msg_out, int_req_out, int_vec_out, lic_req_out, lic_vec_out} = 0;
   // Idle vectors keep moving so a stale value is never mistaken for a request
   always @(posedge clock_in) begin
      if (!int_req_out) int_vec_out <= int_vec_out + 8'h35;
      if (!lic_req_out) lic_vec_out <= ~lic_vec_out;
   end
   task pin(input logic [7:0] v);
      int_vec_out = v;
      int_req_out = 1;
   endtask : pin
   task lic(input logic [7:0] v);
      lic_vec_out = v;
      lic_req_out = 1;
   endtask : lic
   // Only the pin or the message carries a true nonmaskable request
   task nmi(input logic msg);
      nmi_msg_out = msg;
      nmi_pin_out = !msg;
   endtask : nmi
   task drop;
      {nmi_pin_out, nmi_msg_out, int_req_out, lic_req_out} = 0;
   endtask : drop
endmodule : ieg_irq_src

// File: sim/interrupt_exception_gating_bench.sv
module interrupt_exception_gating_bench;
   import ieg_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_in = 0, rst_b_in = 0, retire_valid_in = 0, retire_branch_in = 0, retire_rep_in = 0;
   logic retire_rep_done_in = 0, trap_in = 0, fault_in = 0, abort_in = 0, ibp_match_in = 0;
   logic set_int_enable_instr_in = 0, clear_int_enable_instr_in = 0, pop_flags_instr_in = 0;
   logic interrupt_return_instr_in = 0, task_switch_in = 0, v86_in = 0, gate_is_maskable_request_pin_in = 0;
   logic [1:0]  current_priv_level_in = 0, io_priv_level_in = 3;
   logic [7:0]  fault_vec_in = 8'h0e, exc_vec_in = 8'h08, dispatch_vec_out, iv, lv;
   logic [31:0] retire_next_ip_in = 32'h100, retire_target_in = 32'h200, retire_ip_in = 32'hfc;
   logic [31:0] flags_load_in = 0, return_ip_out, flags_register_out;
   logic        dispatch_out, error_code_ok_out, restartable_out, maskable_ack_out, lic_ack_out;
   logic        lic_illegal_out, nmi_blocked_out, np, nm, ir, lr;
   ieg_event_t  dispatch_class_out;
   int          error_cnt = 0, checks = 0, cycles = 0;
   ieg_irq_src src (.clock_in(clock_in), .nmi_pin_out(np), .nmi_msg_out(nm), .int_req_out(ir),
      .int_vec_out(iv), .lic_req_out(lr), .lic_vec_out(lv));
   ieg_gate DUT (.*, .nmi_pin_in(np), .nmi_msg_in(nm), .maskable_request_pin_in(ir),
      .pin_vec_in(iv), .lic_req_in(lr), .lic_vec_in(lv));
   always #5 clock_in = ~clock_in;
   // Hang guard, far beyond the sequence length
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 2000) begin error_cnt++; results(); end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // One boundary; the answer stands for the single cycle after the take edge
   task go(input logic d, input logic [2:0] c, input logic [7:0] v, input logic [31:0] r);
      logic pr, il;
      pr = ir;
      il = lr && (lv < LIC_VEC_MIN);
      retire_valid_in = 1;
      @(posedge clock_in);
      #1;
      retire_valid_in = 0;
      {trap_in, abort_in, ibp_match_in, retire_branch_in, retire_rep_in, v86_in} = 0;
      {set_int_enable_instr_in, clear_int_enable_instr_in, pop_flags_instr_in} = 0;
      interrupt_return_instr_in = 0;
      src.drop();
      chk(dispatch_out, d);
      chk(maskable_ack_out, d && c == IEG_EV_MASKABLE && pr);
      chk(lic_ack_out, d && c == IEG_EV_MASKABLE && !pr);
      chk(lic_illegal_out, il);
      if (d) begin
         chk(error_code_ok_out, c inside {IEG_EV_TRAP, IEG_EV_ABORT, IEG_EV_FAULT});
         chk(dispatch_class_out, c);
         chk(dispatch_vec_out, v);
         chk(restartable_out, c != IEG_EV_ABORT);
         if (r != 0) chk(return_ip_out, r);
      end
      @(posedge clock_in);
      #1;
   endtask : go
   task results;
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   initial begin
      repeat (12) @(posedge clock_in);
      #1 rst_b_in = 1;
      chk(flags_register_out, FLAGS_RESET);
      chk(nmi_blocked_out, 0);
      trap_in = 1;
      go(1, IEG_EV_TRAP, 8'h08, 32'h100);
      trap_in = 1;
      retire_branch_in = 1;
      go(1, IEG_EV_TRAP, 8'h08, 32'h200);
      abort_in = 1;
      go(1, IEG_EV_ABORT, 8'h08, 0);
      src.pin(8'h05);
      go(0, 0, 0, 0);
      set_int_enable_instr_in = 1;
      go(0, 0, 0, 0);
      chk(flags_register_out[IF_BIT], 1);
      src.pin(8'h02);
      go(1, IEG_EV_MASKABLE, 8'h02, 32'h100);
      chk(nmi_blocked_out, 0);
      src.pin(8'h21);
      go(0, 0, 0, 0);
      src.lic(8'h08);
      go(0, 0, 0, 0);
      src.lic(8'h20);
      go(1, IEG_EV_MASKABLE, 8'h20, 32'h100);
      retire_rep_in = 1;
      src.pin(8'h00);
      go(1, IEG_EV_MASKABLE, 8'h00, 32'hfc);
      {current_priv_level_in, io_priv_level_in} = 4'hc;
      clear_int_enable_instr_in = 1;
      go(1, IEG_EV_FAULT, GPF_VECTOR, 0);
      chk(flags_register_out[IF_BIT], 1);
      {current_priv_level_in, io_priv_level_in} = 4'h3;
      gate_is_maskable_request_pin_in = 1;
      src.pin(8'h10);
      go(1, IEG_EV_MASKABLE, 8'h10, 32'h100);
      chk(flags_register_out[IF_BIT], 0);
      gate_is_maskable_request_pin_in = 0;
      src.nmi(0);
      go(1, IEG_EV_NMI, NMI_VECTOR, 32'h100);
      chk(nmi_blocked_out, 1);
      flags_load_in = 32'h00000202;
      pop_flags_instr_in = 1;
      go(0, 0, 0, 0);
      chk(flags_register_out[IF_BIT], 1);
      src.pin(8'h03);
      go(0, 0, 0, 0);
      v86_in = 1;
      io_priv_level_in = 0;
      interrupt_return_instr_in = 1;
      go(1, IEG_EV_FAULT, GPF_VECTOR, 0);
      chk(nmi_blocked_out, 0);
      io_priv_level_in = 3;
      src.nmi(1);
      go(1, IEG_EV_NMI, NMI_VECTOR, 32'h100);
      interrupt_return_instr_in = 1;
      go(0, 0, 0, 0);
      chk(nmi_blocked_out, 0);
      ibp_match_in = 1;
      go(1, IEG_EV_DEBUG, DBG_VECTOR, 0);
      flags_load_in = 32'h00010202;
      pop_flags_instr_in = 1;
      go(0, 0, 0, 0);
      ibp_match_in = 1;
      go(0, 0, 0, 0);
      exc_vec_in = 8'h04;
      trap_in = 1;
      abort_in = 1;
      go(1, IEG_EV_ABORT, 8'h04, 0);
      fault_vec_in = 8'h0c;
      fault_in = 1;
      go(1, IEG_EV_FAULT, 8'h0c, 32'hfc);
      fault_in = 0;
      flags_load_in = 32'h00000002;
      task_switch_in = 1;
      go(0, 0, 0, 0);
      task_switch_in = 0;
      chk(flags_register_out[IF_BIT], 0);
      set_int_enable_instr_in = 1;
      go(0, 0, 0, 0);
      retire_rep_in = 1;
      retire_rep_done_in = 1;
      src.pin(8'h07);
      go(1, IEG_EV_MASKABLE, 8'h07, 32'h100);
      retire_rep_done_in = 0;
      src.pin(8'h11);
      src.lic(8'h12);
      go(1, IEG_EV_MASKABLE, 8'h11, 32'h100);
      results();
   end
endmodule : interrupt_exception_gating_bench
